/* core/cae_evt_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module cae_evt_counter (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic inc,
  input wire logic clr,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [cae_pkg::DATA_W-1:0] wdata,
  output logic [cae_pkg::CNT_W-1:0] count
);
  import cae_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // Software load wins over a same-cycle increment; wraps silently
  always_comb begin
    count_next = count_reg + CNT_W'(inc);
    if (clr) begin
      count_next = CNT_RST;
    end
    if (wr_lo) begin
      count_next[DATA_W-1:0] = wdata;
    end
    if (wr_hi) begin
      count_next[CNT_W-1:DATA_W] = wdata[CNT_HI_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule
`default_nettype wire

/* core/cae_evt_match.sv */
`timescale 1ns/1ps
`default_nettype none
module cae_evt_match #(
  parameter int IDX = 0
) (
  input wire logic enable,
  input wire logic [7:0] code,
  input wire logic [cae_pkg::UMASK_W-1:0] umask,
  input wire logic [cae_pkg::XTRA_W-1:0] xtra,
  input wire logic lookup_valid,
  input wire logic [7:0] lookup_state,
  input wire logic [cae_pkg::XTRA_W-1:0] lookup_class,
  input wire logic victim_valid,
  input wire logic [3:0] victim_state,
  input wire logic victim_clean,
  input wire logic victim_remote,
  input wire logic mem_write_valid,
  input wire logic [3:0] mem_write_type,
  input wire logic [7:0] misc_event,
  input wire logic bcast_req,
  input wire logic [5:0] bcast_kind,
  input wire logic reject_valid,
  input wire logic [7:0] reject_lo,
  input wire logic [cae_pkg::XTRA_W-1:0] reject_reason,
  output logic inc
);
  import cae_pkg::*;

  logic low_slot;
  logic class_ok;
  logic loc_ok;
  logic hit;

  assign low_slot = (IDX < RESTRICT_LIMIT);
  // Empty filter admits every class; set bits admit matching classes
  assign class_ok = (xtra == '0) || ((xtra & lookup_class) != '0); // see [RULE_06] [RULE_07]
  // Neither locality bit means both localities
  assign loc_ok = (!xtra[VIC_LOCAL_BIT] && !xtra[VIC_REMOTE_BIT]) ||
                  (xtra[VIC_LOCAL_BIT] && !victim_remote) ||
                  (xtra[VIC_REMOTE_BIT] && victim_remote); // see [RULE_10]

  always_comb begin
    hit = 1'b0;
    case (code)
      EV_LOOKUP: begin
        // One lookup per cycle; a multi-lookup request shows up repeatedly
        hit = lookup_valid && ((umask & lookup_state) != '0) && class_ok; // see [RULE_02] [RULE_03] [RULE_05]
      end
      EV_VICTIM: begin
        hit = victim_valid && !victim_clean && loc_ok &&
              ((umask[3:0] & VIC_STATE_MASK & victim_state) != '0); // see [RULE_08] [RULE_09]
      end
      EV_MEM_WRITE: begin
        hit = mem_write_valid && ((umask[3:0] & mem_write_type) != '0); // see [RULE_11]
      end
      EV_MISC: begin
        hit = (umask & misc_event) != '0; // see [RULE_12] [RULE_13] [RULE_14]
      end
      EV_SNOOP_BCAST: begin
        // Pulse per request, never per generated snoop
        hit = bcast_req && ((umask[5:0] & bcast_kind) != '0); // see [RULE_15] [RULE_16]
      end
      EV_PIPE_REJECT: begin
        hit = reject_valid && (((umask & reject_lo) != '0) ||
              ((xtra & reject_reason) != '0)); // see [RULE_17]
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  assign inc = enable && hit && (low_slot || !cae_restricted(code)); // see [RULE_01] [RULE_17]

endmodule
`default_nettype wire

/* core/cae_pkg.sv */
`default_nettype none
package cae_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CNT = 5;
  localparam int RESTRICT_LIMIT = 4;
  localparam int UMASK_W = 8;
  localparam int XTRA_W = 26;
  localparam int CNT_W = 48;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_HI_W = CNT_W - DATA_W;

  ////////////////////////////////////////////////////////////////////////////
  // Event codes
  localparam logic [7:0] EV_MEM_WRITE = 8'h5b;
  localparam logic [7:0] EV_LOOKUP = 8'h34;
  localparam logic [7:0] EV_VICTIM = 8'h37;
  localparam logic [7:0] EV_MISC = 8'h39;
  localparam logic [7:0] EV_SNOOP_BCAST = 8'h55;
  localparam logic [7:0] EV_PIPE_REJECT = 8'h42;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: addr[7:4] counter, addr[3:2] register
  localparam int SLOT_LSB = 4;
  localparam int SLOT_W = 4;
  localparam int REG_LSB = 2;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_FLT = 2'h1;
  localparam logic [1:0] REG_CNT_LO = 2'h2;
  localparam logic [1:0] REG_CNT_HI = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and reset values
  localparam int CTL_CODE_LSB = 0;
  localparam int CTL_UMASK_LSB = 8;
  localparam int CTL_CLR_BIT = 17;
  localparam int CTL_EN_BIT = 22;
  localparam logic [31:0] CTL_WMASK = 32'h0040_ffff;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [XTRA_W-1:0] FLT_RST = 26'h000_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 48'h0000_0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Victim locality bits in the extended filter, victim state mask and the remote-lookup filter value
  localparam int VIC_LOCAL_BIT = 5;
  localparam int VIC_REMOTE_BIT = 7;
  localparam logic [3:0] VIC_STATE_MASK = 4'hf;
  localparam logic [XTRA_W-1:0] LOOKUP_ALL_REMOTE = 26'h000_1e20;

  // Events that live on the low counters only
  function automatic logic cae_restricted(input logic [7:0] code);
    cae_restricted = (code == EV_LOOKUP) || (code == EV_VICTIM) ||
                     (code == EV_MISC) || (code == EV_PIPE_REJECT);
  endfunction

endpackage
`default_nettype wire

/* core/cae_top.sv */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] Lookup event counts once per cycle, counters 0-3
// [RULE_02] Each lookup of a request counts separately
// [RULE_03] No line-state bit selected means no counting
// [RULE_04] Software must pick at least one state
// [RULE_05] Lookup selector bits map one outcome each
// [RULE_06] Extended filter bits admit request classes
// [RULE_07] All states plus 0x1E20 counts remote lookups
// [RULE_08] Victim event counts evictions for fills
// [RULE_09] Clean evictions never count as victims
// [RULE_10] Victim state selector, local/remote home filter
// [RULE_11] Memory-write selector picks full/partial, normal/isochronous
// [RULE_12] Misc bit zero counts silent snoop evictions
// [RULE_13] Misc bit one counts combining-write aliasing
// [RULE_14] Misc bit counts ownership reads hitting shared
// [RULE_15] Snoop broadcast counts once per request
// [RULE_16] Broadcast selector separates request kinds and off
// [RULE_17] Pipe reject on counters 0-3, reason filtered
module cae_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [cae_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cae_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cae_pkg::DATA_W-1:0] reg_rdata,
  input wire logic lookup_valid,
  input wire logic [7:0] lookup_state,
  input wire logic [cae_pkg::XTRA_W-1:0] lookup_class,
  input wire logic victim_valid,
  input wire logic [3:0] victim_state,
  input wire logic victim_clean,
  input wire logic victim_remote,
  input wire logic mem_write_valid,
  input wire logic [3:0] mem_write_type,
  input wire logic [7:0] misc_event,
  input wire logic bcast_req,
  input wire logic [5:0] bcast_kind,
  input wire logic reject_valid,
  input wire logic [7:0] reject_lo,
  input wire logic [cae_pkg::XTRA_W-1:0] reject_reason
);
  import cae_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic slot_hit(input logic [ADDR_W-1:0] addr,
                                    input int idx,
                                    input logic [1:0] regsel);
    slot_hit = (int'(addr[SLOT_LSB +: SLOT_W]) == idx) &&
               (addr[REG_LSB +: 2] == regsel) && (addr[1:0] == 2'h0);
  endfunction

  logic [DATA_W-1:0] ctl_reg [NUM_CNT];
  logic [XTRA_W-1:0] flt_reg [NUM_CNT];
  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [NUM_CNT-1:0] inc_w;
  logic [NUM_CNT-1:0] clr_w;
  logic [NUM_CNT-1:0] wr_lo_w;
  logic [NUM_CNT-1:0] wr_hi_w;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter control, filter, matcher and count

  genvar i;
  generate
    for (i = 0; i < NUM_CNT; i++) begin : g_cnt
      logic wr_ctl;
      logic wr_flt;

      assign wr_ctl = reg_wr && slot_hit(reg_addr, i, REG_CTL);
      assign wr_flt = reg_wr && slot_hit(reg_addr, i, REG_FLT);
      // Clear bit is write-only and acts once
      assign clr_w[i] = wr_ctl && reg_wdata[CTL_CLR_BIT];
      assign wr_lo_w[i] = reg_wr && slot_hit(reg_addr, i, REG_CNT_LO);
      assign wr_hi_w[i] = reg_wr && slot_hit(reg_addr, i, REG_CNT_HI);

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          ctl_reg[i] <= CTL_RST;
        end else if (wr_ctl) begin
          ctl_reg[i] <= reg_wdata & CTL_WMASK;
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          flt_reg[i] <= FLT_RST;
        end else if (wr_flt) begin
          flt_reg[i] <= reg_wdata[XTRA_W-1:0];
        end
      end

      cae_evt_match #(
        .IDX(i)
      ) u_match (
        .enable(ctl_reg[i][CTL_EN_BIT]),
        .code(ctl_reg[i][CTL_CODE_LSB +: 8]),
        .umask(ctl_reg[i][CTL_UMASK_LSB +: UMASK_W]),
        .xtra(flt_reg[i]),
        .lookup_valid(lookup_valid),
        .lookup_state(lookup_state),
        .lookup_class(lookup_class),
        .victim_valid(victim_valid),
        .victim_state(victim_state),
        .victim_clean(victim_clean),
        .victim_remote(victim_remote),
        .mem_write_valid(mem_write_valid),
        .mem_write_type(mem_write_type),
        .misc_event(misc_event),
        .bcast_req(bcast_req),
        .bcast_kind(bcast_kind),
        .reject_valid(reject_valid),
        .reject_lo(reject_lo),
        .reject_reason(reject_reason),
        .inc(inc_w[i])
      );

      cae_evt_counter u_counter (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .inc(inc_w[i]),
        .clr(clr_w[i]),
        .wr_lo(wr_lo_w[i]),
        .wr_hi(wr_hi_w[i]),
        .wdata(reg_wdata),
        .count(cnt_val[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data valid in the cycle after the strobe only

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      for (int k = 0; k < NUM_CNT; k++) begin
        if (slot_hit(reg_addr, k, REG_CTL)) begin
          rdata_next = ctl_reg[k];
        end
        if (slot_hit(reg_addr, k, REG_FLT)) begin
          rdata_next = {{(DATA_W-XTRA_W){1'b0}}, flt_reg[k]};
        end
        if (slot_hit(reg_addr, k, REG_CNT_LO)) begin
          rdata_next = cnt_val[k][DATA_W-1:0];
        end
        if (slot_hit(reg_addr, k, REG_CNT_HI)) begin
          rdata_next = {{(DATA_W-CNT_HI_W){1'b0}},
                        cnt_val[k][CNT_W-1:DATA_W]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  generate
    for (i = 0; i < NUM_CNT; i++) begin : g_chk
      logic [7:0] code_c;
      logic [7:0] um_c;
      logic en_c;
      logic sw_c;

      assign code_c = ctl_reg[i][CTL_CODE_LSB +: 8];
      assign um_c = ctl_reg[i][CTL_UMASK_LSB +: UMASK_W];
      assign en_c = ctl_reg[i][CTL_EN_BIT];
      assign sw_c = clr_w[i] || wr_lo_w[i] || wr_hi_w[i];

      AST_CNT_STEP: assert property ( // see [RULE_02]
        !sw_c ##1 1'b1 |->
          cnt_val[i] == $past(cnt_val[i]) + CNT_W'($past(inc_w[i])))
        else $error("counter step differs from increment");

      if (i >= RESTRICT_LIMIT) begin : g_hi
        AST_LOOKUP_RESTRICT: assert property ( // see [RULE_01]
          (code_c == EV_LOOKUP) && !sw_c |=> $stable(cnt_val[i]))
          else $error("lookup counted on a high counter");
        AST_REJECT_RESTRICT: assert property ( // see [RULE_17]
          (code_c == EV_PIPE_REJECT) |-> !inc_w[i])
          else $error("reject counted on a high counter");
        // Victim and misc share the low-counter restriction
        AST_HIGH_RESTRICT: assert property ( // see [RULE_01]
          cae_restricted(code_c) |-> !inc_w[i])
          else $error("restricted event counted on a high counter");
      end else begin : g_lo
        AST_LOOKUP_STATE: assert property ( // see [RULE_05]
          en_c && (code_c == EV_LOOKUP) && lookup_valid &&
          ((um_c & lookup_state) != '0) && (flt_reg[i] == '0) && !sw_c
          |=> cnt_val[i] == $past(cnt_val[i]) + 1)
          else $error("selected lookup outcome not counted");
        AST_MISC_SILENT: assert property ( // see [RULE_12]
          en_c && (code_c == EV_MISC) && um_c[0] && misc_event[0]
          |-> inc_w[i])
          else $error("silent snoop eviction not counted");
        AST_REJECT_REASON: assert property ( // see [RULE_17]
          en_c && (code_c == EV_PIPE_REJECT) && reject_valid &&
          ((flt_reg[i] & reject_reason) != '0) |-> inc_w[i])
          else $error("selected reject reason not counted");

        AST_REJECT_SELECT: assert property ( // see [RULE_17]
          en_c && (code_c == EV_PIPE_REJECT) && reject_valid &&
          ((um_c & reject_lo) != '0) |-> inc_w[i])
          else $error("selector reject reason not counted");
        AST_VICTIM_FILL: assert property ( // see [RULE_08]
          en_c && (code_c == EV_VICTIM) && victim_valid && !victim_clean &&
          ((um_c[3:0] & victim_state) != '0) &&
          !flt_reg[i][VIC_LOCAL_BIT] &&
          (!flt_reg[i][VIC_REMOTE_BIT] || victim_remote) |-> inc_w[i])
          else $error("dirty victim not counted");
        AST_MISC_ALIAS: assert property ( // see [RULE_13]
          en_c && (code_c == EV_MISC) && um_c[1] && misc_event[1]
          |-> inc_w[i])
          else $error("combining write alias not counted");
        AST_MISC_SHARED: assert property ( // see [RULE_14]
          en_c && (code_c == EV_MISC) && um_c[3] && misc_event[3]
          |-> inc_w[i])
          else $error("ownership read shared hit not counted");
        AST_MISC_UNSEL: assert property ( // see [RULE_12]
          (code_c == EV_MISC) && ((um_c & misc_event) == '0) |-> !inc_w[i])
          else $error("unselected misc event counted");
      end

      AST_LOOKUP_NOSTATE: assert property ( // see [RULE_03]
        (code_c == EV_LOOKUP) && (um_c == '0) |-> !inc_w[i])
        else $error("lookup counted with no state selected");
      AST_VICTIM_CLEAN: assert property ( // see [RULE_09]
        (code_c == EV_VICTIM) && victim_clean |-> !inc_w[i])
        else $error("clean eviction counted as victim");
      AST_VICTIM_LOCAL: assert property ( // see [RULE_10]
        (code_c == EV_VICTIM) && flt_reg[i][VIC_REMOTE_BIT] &&
        !flt_reg[i][VIC_LOCAL_BIT] && !victim_remote |-> !inc_w[i])
        else $error("local victim counted under remote-only filter");
      AST_MEMWR_TYPE: assert property ( // see [RULE_11]
        en_c && (code_c == EV_MEM_WRITE) && mem_write_valid &&
        ((um_c[3:0] & mem_write_type) != '0) |-> inc_w[i])
        else $error("selected memory write not counted");
      AST_BCAST_ONCE: assert property ( // see [RULE_15]
        (code_c == EV_SNOOP_BCAST) && !bcast_req |-> !inc_w[i])
        else $error("broadcast counted without a request");
      AST_DISABLED: assert property (
        !en_c && !sw_c |=> $stable(cnt_val[i]))
        else $error("disabled counter moved");
      AST_DISABLED_INC: assert property (
        !en_c |-> !inc_w[i])
        else $error("disabled counter requested an increment");
      AST_CLEAR: assert property (
        clr_w[i] |=> cnt_val[i] == '0)
        else $error("clear did not zero the counter");
      // A load beats a same-cycle increment so software sees what it wrote
      AST_LOAD_LO: assert property (
        wr_lo_w[i] |=> cnt_val[i][DATA_W-1:0] == $past(reg_wdata))
        else $error("low count word not loaded");
      AST_LOAD_HI: assert property (
        wr_hi_w[i] |=>
          cnt_val[i][CNT_W-1:DATA_W] == $past(reg_wdata[CNT_HI_W-1:0]))
        else $error("high count word not loaded");
      AST_LOOKUP_CLASS: assert property ( // see [RULE_06]
        (code_c == EV_LOOKUP) && (flt_reg[i] != '0) &&
        ((flt_reg[i] & lookup_class) == '0) |-> !inc_w[i])
        else $error("lookup of an unselected class counted");
      AST_MEMWR_NOSEL: assert property ( // see [RULE_11]
        (code_c == EV_MEM_WRITE) && ((um_c[3:0] & mem_write_type) == '0)
        |-> !inc_w[i])
        else $error("unselected memory write counted");
      AST_BCAST_KIND: assert property ( // see [RULE_16]
        en_c && (code_c == EV_SNOOP_BCAST) && bcast_req &&
        ((um_c[5:0] & bcast_kind) != '0) |-> inc_w[i])
        else $error("selected broadcast kind not counted");
      AST_LOOKUP_NONE: assert property ( // see [RULE_02]
        (code_c == EV_LOOKUP) && !lookup_valid |-> !inc_w[i])
        else $error("lookup counted without a lookup");
      AST_VICTIM_NONE: assert property ( // see [RULE_08]
        (code_c == EV_VICTIM) && !victim_valid |-> !inc_w[i])
        else $error("victim counted without an eviction");
      AST_REJECT_NONE: assert property ( // see [RULE_17]
        (code_c == EV_PIPE_REJECT) && !reject_valid |-> !inc_w[i])
        else $error("reject counted without a reject");
    end
  endgenerate

  AST_READ_CTL: assert property (
    reg_rd && (reg_addr == 8'h00) |=> reg_rdata == $past(ctl_reg[0]))
    else $error("control read data wrong");

  AST_READ_FLT: assert property (
    reg_rd && (reg_addr == 8'h04) |=>
      reg_rdata == {{(DATA_W-XTRA_W){1'b0}}, $past(flt_reg[0])})
    else $error("filter read data wrong");
  AST_READ_CNT_LO: assert property (
    reg_rd && (reg_addr == 8'h08) |=>
      reg_rdata == $past(cnt_val[0][DATA_W-1:0]))
    else $error("count read data wrong");
  // Unmapped slots read as zero rather than aliasing a real counter
  AST_READ_UNMAPPED: assert property (
    reg_rd && (int'(reg_addr[SLOT_LSB +: SLOT_W]) >= NUM_CNT) |=>
      reg_rdata == '0)
    else $error("unmapped read returned data");
  AST_READ_MISALIGNED: assert property (
    reg_rd && (reg_addr[1:0] != 2'h0) |=> reg_rdata == '0)
    else $error("misaligned read returned data");
  // Data stands one cycle only, so a stale value is never reused
  AST_READ_IDLE: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");
  AST_WRITE_CTL1: assert property (
    reg_wr && (reg_addr == 8'h10) |=>
      ctl_reg[1] == ($past(reg_wdata) & CTL_WMASK))
    else $error("control write not stored");

  COV_LOOKUP_REMOTE: cover property ( // see [RULE_07]
    ctl_reg[1][CTL_EN_BIT] && (ctl_reg[1][7:0] == EV_LOOKUP) &&
    (flt_reg[1] == LOOKUP_ALL_REMOTE) && inc_w[1]);
  COV_VICTIM: cover property (
    (ctl_reg[2][7:0] == EV_VICTIM) && inc_w[2]);
  COV_REJECT_SELECT: cover property (
    (ctl_reg[0][7:0] == EV_PIPE_REJECT) && reject_valid &&
    (reject_lo != '0) && inc_w[0]);
  COV_BCAST_HIGH: cover property (
    (ctl_reg[4][7:0] == EV_SNOOP_BCAST) && inc_w[4]);
  COV_BACK_TO_BACK: cover property (inc_w[0] ##1 inc_w[0]);

endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cae_pkg::*;

  `define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

  ////////////////////////////////////////////////////////////////////////////
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic lookup_valid = 1'b0;
  logic [7:0] lookup_state = '0;
  logic [XTRA_W-1:0] lookup_class = '0;
  logic victim_valid = 1'b0;
  logic [3:0] victim_state = '0;
  logic victim_clean = 1'b0;
  logic victim_remote = 1'b0;
  logic mem_write_valid = 1'b0;
  logic [3:0] mem_write_type = '0;
  logic [7:0] misc_event = '0;
  logic bcast_req = 1'b0;
  logic [5:0] bcast_kind = '0;
  logic reject_valid = 1'b0;
  logic [7:0] reject_lo = '0;
  logic [XTRA_W-1:0] reject_reason = '0;
  int bad_count = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  cae_top u_cae_top (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lookup_valid(lookup_valid),
    .lookup_state(lookup_state), .lookup_class(lookup_class),
    .victim_valid(victim_valid), .victim_state(victim_state),
    .victim_clean(victim_clean), .victim_remote(victim_remote),
    .mem_write_valid(mem_write_valid), .mem_write_type(mem_write_type),
    .misc_event(misc_event), .bcast_req(bcast_req),
    .bcast_kind(bcast_kind), .reject_valid(reject_valid),
    .reject_lo(reject_lo), .reject_reason(reject_reason)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; strobes drop one edge later so no double drive per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  // Clear on the same write so each scenario starts from zero
  task automatic cfg(input int n, input logic [7:0] code,
                     input logic [7:0] sel, input logic [XTRA_W-1:0] f);
    wr(8'(n * 16 + 4), {6'h00, f});
    wr(8'(n * 16), {9'h000, 1'b1, 4'h0, 1'b1, 1'b0, sel, code});
  endtask

  task automatic idle();
    @(posedge clk_sys);
    lookup_valid <= 1'b0;
    victim_valid <= 1'b0;
    victim_clean <= 1'b0;
    mem_write_valid <= 1'b0;
    misc_event <= 8'h00;
    bcast_req <= 1'b0;
    reject_valid <= 1'b0;
  endtask

  // Events were set at the last edge; keep them k cycles in all
  task automatic hold(input int k);
    repeat (k - 1) @(posedge clk_sys);
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk_rd(8'h00, CTL_RST);
    chk_rd(8'h04, 32'(FLT_RST));
    chk_rd(8'h08, 32'h0000_0000);
    wr(8'h50, 32'hffff_ffff);
    chk_rd(8'h50, 32'h0000_0000);
    wr(8'h10, 32'hffff_ffff);
    chk_rd(8'h10, CTL_WMASK);
  endtask

  task automatic t_count();
    wr(8'h08, 32'h89ab_cdef);
    wr(8'h0c, 32'hdead_4567);
    chk_rd(8'h08, 32'h89ab_cdef);
    chk_rd(8'h0c, 32'h0000_4567);
    // Read data must fall back to zero one cycle later
    @(posedge clk_sys);
    #1 `CHK(reg_rdata, 32'h0)
    chk_rd(8'h01, 32'h0);
    wr(8'h00, 32'h0002_0000);
    chk_rd(8'h00, 32'h0);
    chk_rd(8'h08, 32'h0);
    chk_rd(8'h0c, 32'h0);
  endtask

  task automatic t_lookup();
    cfg(0, EV_LOOKUP, 8'h00, '0);
    @(posedge clk_sys);
    lookup_valid <= 1'b1;
    lookup_state <= 8'hff;
    hold(3);
    chk_rd(8'h08, 32'h0);
    cfg(0, EV_LOOKUP, 8'h01, '0);
    cfg(4, EV_LOOKUP, 8'h01, '0);
    @(posedge clk_sys);
    lookup_valid <= 1'b1;
    lookup_state <= 8'h01;
    hold(3);
    chk_rd(8'h08, 32'h3);
    chk_rd(8'h48, 32'h0);
    cfg(0, EV_LOOKUP, 8'hff, '0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      lookup_valid <= 1'b1;
      lookup_state <= 8'(1 << i);
    end
    idle();
    chk_rd(8'h08, 32'h8);
  endtask

  task automatic t_remote();
    cfg(1, EV_LOOKUP, 8'hff, LOOKUP_ALL_REMOTE);
    @(posedge clk_sys);
    lookup_valid <= 1'b1;
    lookup_state <= 8'h10;
    lookup_class <= 26'h000_0020;
    hold(2);
    @(posedge clk_sys);
    lookup_valid <= 1'b1;
    lookup_class <= 26'h000_0001;
    hold(1);
    chk_rd(8'h18, 32'h2);
  endtask

  task automatic t_victim();
    cfg(2, EV_VICTIM, 8'h0f, 26'(1 << VIC_REMOTE_BIT));
    @(posedge clk_sys);
    victim_valid <= 1'b1;
    victim_state <= 4'h1;
    victim_remote <= 1'b1;
    hold(1);
    @(posedge clk_sys);
    victim_valid <= 1'b1;
    victim_clean <= 1'b1;
    hold(1);
    chk_rd(8'h28, 32'h1);
    @(posedge clk_sys);
    victim_valid <= 1'b1;
    victim_remote <= 1'b0;
    hold(2);
    chk_rd(8'h28, 32'h1);
  endtask

  task automatic t_memwr();
    cfg(4, EV_MEM_WRITE, 8'h08, '0);
    @(posedge clk_sys);
    mem_write_valid <= 1'b1;
    mem_write_type <= 4'h8;
    hold(2);
    @(posedge clk_sys);
    mem_write_valid <= 1'b1;
    mem_write_type <= 4'h1;
    hold(1);
    chk_rd(8'h48, 32'h2);
  endtask

  task automatic t_misc();
    cfg(3, EV_MISC, 8'h0b, '0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      misc_event <= 8'(1 << i);
    end
    idle();
    chk_rd(8'h38, 32'h3);
  endtask

  task automatic t_bcast();
    cfg(4, EV_SNOOP_BCAST, 8'h10, '0);
    @(posedge clk_sys);
    bcast_req <= 1'b1;
    bcast_kind <= 6'h30;
    hold(1);
    @(posedge clk_sys);
    bcast_req <= 1'b1;
    bcast_kind <= 6'h20;
    hold(1);
    chk_rd(8'h48, 32'h1);
  endtask

  task automatic t_reject();
    cfg(0, EV_PIPE_REJECT, 8'h02, 26'h000_0004);
    cfg(4, EV_PIPE_REJECT, 8'h02, 26'h000_0004);
    @(posedge clk_sys);
    reject_valid <= 1'b1;
    reject_reason <= 26'h000_0004;
    hold(1);
    @(posedge clk_sys);
    reject_valid <= 1'b1;
    reject_reason <= 26'h000_0002;
    hold(1);
    @(posedge clk_sys);
    reject_valid <= 1'b1;
    reject_lo <= 8'h02;
    hold(1);
    @(posedge clk_sys);
    reject_valid <= 1'b1;
    reject_lo <= 8'h01;
    hold(1);
    chk_rd(8'h08, 32'h2);
    chk_rd(8'h48, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_count();
    t_lookup();
    t_remote();
    t_victim();
    t_memwr();
    t_misc();
    t_bcast();
    t_reject();
    report_and_stop();
  end
endmodule
`default_nettype wire
